// File: design/nibble_core.v
/*
  nibble core: fetch, decode and execute for a 4-bit microcomputer core,
  with a 32-bit apb register slave for run control and observation.
  assumes a program rom and data ram whose read data are valid in the
  cycle the address outputs stand (asynchronous read), ram written
  on the clock edge while ram_we_out is high, and conv_done_in on clk_in.
*/
`timescale 1ns/1ps
`include "nibble_core_defines.vh"

module nibble_core (
  // clock and reset
  input  wire                clk_in,
  input  wire                nrst_in,
  // apb slave
  input  wire                psel_in,
  input  wire                penable_in,
  input  wire                pwrite_in,
  input  wire [`ADDR_W-1:0]  paddr_in,
  input  wire [31:0]         pwdata_in,
  output reg  [31:0]         prdata_out,
  output reg                 pready_out,
  output reg                 pslverr_out,
  // program memory
  output reg  [`PC_W-1:0]    rom_addr_out,
  input  wire [`IR_W-1:0]    rom_data_in,
  // data memory
  output reg  [`DP_W-1:0]    ram_addr_out,
  input  wire [3:0]          ram_rdata_in,
  output reg  [3:0]          ram_wdata_out,
  output reg                 ram_we_out,
  // pins
  input  wire [3:0]          port0_in,
  input  wire [2:0]          port2_in,
  // converter and system control
  input  wire                conv_done_in,
  output reg                 adc_start_out,
  output reg                 cmp_start_out,
  output reg                 backup_mode_out,
  output reg                 wdt_stop_en_out,
  output reg  [1:0]          osc_sel_out
);

  reg  [6:0]          state_r;
  reg  [`PC_W-1:0]    pc_r;
  reg  [`SP_W-1:0]    stack_index_r;
  reg  [`PC_W-1:0]    return_stack [0:`STK_DEPTH-1];
  reg  [3:0]          acc_r;
  reg                 carry_flag_r;
  reg  [2:0]          aux_index_reg_r;
  reg                 skip_r;
  reg                 suppress_r;
  reg                 is_call_r;
  reg  [5:0]          far_page_r;
  reg                 pof_armed_r;
  reg                 conversion_done_flag_r;
  reg                 run_r;
  reg  [3:0]          converter_ctrl_one_r;
  reg  [3:0]          p0_s1_r;
  reg  [3:0]          p0_s2_r;
  reg  [3:0]          p0_s3_r;
  reg  [3:0]          p0_q_r;
  reg  [2:0]          p2_s1_r;
  reg  [2:0]          p2_s2_r;
  reg  [2:0]          p2_s3_r;
  reg  [2:0]          p2_q_r;

  wire [`IR_W-1:0]    ir = rom_data_in;
  wire [`PC_W-1:0]    pc_inc = pc_r + 14'h0001;
  wire [`HALF_W-1:0]  pc_page_part = pc_r[13:7];
  wire [`SP_W-1:0]    sp_inc = stack_index_r + 3'h1;
  wire [`SP_W-1:0]    sp_dec = stack_index_r - 3'h1;
  wire [6:0]          idx_inpage = {aux_index_reg_r, acc_r};

  wire is_b    = (ir[9:7] == `PFX_B);
  wire is_bl   = (ir[9:6] == `PFX_BL);
  wire is_bm   = (ir[9:6] == `PFX_BM);
  wire is_bla  = (ir[9:6] == `PFX_BLA);
  wire is_table_ref_op = (ir[9:6] == `PFX_TABLE_REF_OP);
  wire is_la   = (ir[9:4] == `PFX_LA);
  wire is_lz   = (ir[9:2] == `PFX_LZ);
  wire is_rt   = (ir == `OP_RT);
  wire is_rts  = (ir == `OP_RTS);
  // exact codes take priority over the load-xy group they overlap
  wire is_exact = (ir == `OP_READ_PORT0_OP) || (ir == `OP_READ_PORT2_OP) || (ir[9:4] == 6'h29);
  wire is_lxy  = (ir[9:8] == `PFX_LXY) && !is_exact;
  wire one_cycle_when_skipped = is_rt | is_rts | is_table_ref_op;

  // pin inputs: three stages, a bit changes once stages two and three agree
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p0_s1_r <= 4'h0;
      p0_s2_r <= 4'h0;
      p0_s3_r <= 4'h0;
      p0_q_r  <= 4'h0;
      p2_s1_r <= 3'h0;
      p2_s2_r <= 3'h0;
      p2_s3_r <= 3'h0;
      p2_q_r  <= 3'h0;
    end else begin
      p0_s1_r <= port0_in;
      p0_s2_r <= p0_s1_r;
      p0_s3_r <= p0_s2_r;
      p0_q_r  <= (p0_s2_r & ~(p0_s2_r ^ p0_s3_r)) | (p0_q_r & (p0_s2_r ^ p0_s3_r));
      p2_s1_r <= port2_in;
      p2_s2_r <= p2_s1_r;
      p2_s3_r <= p2_s2_r;
      p2_q_r  <= (p2_s2_r & ~(p2_s2_r ^ p2_s3_r)) | (p2_q_r & (p2_s2_r ^ p2_s3_r));
    end
  end

  // return stack storage has no reset; contents are only read after a push
  always @(posedge clk_in) begin
    if (state_r == `ST_WORD2 && !suppress_r && is_call_r) begin
      return_stack[sp_inc] <= pc_r;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r                <= `ST_IDLE;
      pc_r                   <= `PC_RST;
      stack_index_r          <= `SP_RST;
      acc_r                  <= 4'h0;
      carry_flag_r           <= 1'b0;
      aux_index_reg_r        <= 3'h0;
      skip_r                 <= 1'b0;
      suppress_r             <= 1'b0;
      is_call_r              <= 1'b0;
      far_page_r             <= 6'h00;
      pof_armed_r            <= 1'b0;
      conversion_done_flag_r <= 1'b0;
      rom_addr_out           <= `PC_RST;
      ram_addr_out           <= 10'h000;
      ram_wdata_out          <= 4'h0;
      ram_we_out             <= 1'b0;
      adc_start_out          <= 1'b0;
      cmp_start_out          <= 1'b0;
      backup_mode_out        <= 1'b0;
      wdt_stop_en_out        <= 1'b0;
      osc_sel_out            <= `OSC_ONCHIP;
    end else begin
      ram_we_out    <= 1'b0;
      adc_start_out <= 1'b0;
      cmp_start_out <= 1'b0;
      // done event wins over a clear by the start instruction in the same cycle
      if (conv_done_in) begin
        conversion_done_flag_r <= 1'b1;
      end else if (state_r == `ST_EXEC && !skip_r && ir == `OP_CONVERTER_START_OP) begin
        conversion_done_flag_r <= 1'b0;
      end
      case (state_r)
        `ST_IDLE: begin
          if (run_r) begin
            state_r <= `ST_FETCH;
          end
        end
        `ST_FETCH: begin
          if (!run_r) begin
            state_r <= `ST_IDLE;
          end else begin
            rom_addr_out <= pc_r;
            pc_r         <= pc_inc;
            state_r      <= `ST_EXEC;
          end
        end
        `ST_EXEC: begin
          state_r <= `ST_FETCH;
          if (ir != `OP_POWER_OFF_ARM_OP) begin
            pof_armed_r <= 1'b0;
          end
          if (skip_r) begin
            // suppressed: no effect, counter already advanced by one only
            skip_r <= 1'b0;
            if (is_bl || is_bm) begin
              // second word still fetched so the timing matches
              rom_addr_out <= pc_r;
              pc_r         <= pc_inc;
              suppress_r   <= 1'b1;
              state_r      <= `ST_WORD2;
            end else if (one_cycle_when_skipped) begin
              state_r <= `ST_FETCH;
            end
          end else if (is_b) begin
            pc_r[6:0] <= ir[6:0];
          end else if (is_bl || is_bm) begin
            far_page_r   <= ir[5:0];
            is_call_r    <= is_bm;
            suppress_r   <= 1'b0;
            rom_addr_out <= pc_r;
            pc_r         <= pc_inc;
            state_r      <= `ST_WORD2;
          end else if (is_bla) begin
            pc_r <= {1'b0, ir[5:0], idx_inpage};
          end else if (is_table_ref_op) begin
            rom_addr_out <= {1'b0, ir[5:0], idx_inpage};
            state_r      <= `ST_TAB;
          end else if (is_rt || is_rts) begin
            pc_r          <= return_stack[stack_index_r];
            stack_index_r <= sp_dec;
            skip_r        <= is_rts;
            state_r       <= `ST_HOLD;
          end else if (is_la) begin
            acc_r <= ir[3:0];
          end else if (is_lz) begin
            ram_addr_out[9:8] <= ir[1:0];
          end else if (is_lxy) begin
            ram_addr_out[7:0] <= ir[7:0];
          end else begin
            case (ir)
              `OP_AND:  acc_r <= acc_r & ram_rdata_in;
              `OP_AM:   acc_r <= acc_r + ram_rdata_in;
              `OP_RC:   carry_flag_r <= 1'b0;
              `OP_SC:   carry_flag_r <= 1'b1;
              `OP_SZC:  skip_r <= ~carry_flag_r;
              `OP_SEAM: skip_r <= (acc_r == ram_rdata_in);
              `OP_TDA:  aux_index_reg_r <= acc_r[2:0];
              `OP_TMA: begin
                ram_wdata_out <= acc_r;
                ram_we_out    <= 1'b1;
              end
              `OP_READ_PORT0_OP: acc_r <= p0_q_r;
              `OP_READ_PORT2_OP: acc_r[2:0] <= p2_q_r;
              `OP_CONVERTER_START_OP: begin
                adc_start_out <= ~converter_ctrl_one_r[`CONV_MODE];
                cmp_start_out <= converter_ctrl_one_r[`CONV_MODE];
              end
              `OP_POWER_OFF_ARM_OP: pof_armed_r <= 1'b1;
              `OP_POF: begin
                // unarmed power-off behaves as a no-operation
                if (pof_armed_r) begin
                  backup_mode_out <= 1'b1;
                  state_r         <= `ST_OFF;
                end
              end
              `OP_WATCHDOG_HALT_ARM_OP: wdt_stop_en_out <= 1'b1;
              `OP_SEL_CERAMIC_OSC_OP: osc_sel_out <= `OSC_CERAMIC;
              `OP_SEL_RC_OSC_OP: osc_sel_out <= `OSC_RC;
              `OP_SEL_CRYSTAL_OSC_OP: osc_sel_out <= `OSC_XTAL;
              default: ;
            endcase
          end
        end
        `ST_WORD2: begin
          state_r <= `ST_FETCH;
          if (!suppress_r) begin
            if (is_call_r) begin
              stack_index_r <= sp_inc;
            end
            pc_r <= {1'b0, far_page_r, ir[6:0]};
          end
          suppress_r <= 1'b0;
        end
        `ST_TAB: begin
          acc_r   <= ir[3:0];
          state_r <= `ST_HOLD;
        end
        `ST_HOLD: begin
          state_r <= `ST_FETCH;
        end
        `ST_OFF: begin
          // back-up: core state held until system reset; the done flag and apb registers still update
          state_r <= `ST_OFF;
        end
        default: state_r <= `ST_IDLE;
      endcase
    end
  end

  // apb slave: zero wait states, read data captured in the setup cycle
  wire        setup  = psel_in && !penable_in;
  wire        access = psel_in && penable_in && pready_out;
  wire        mapped = (paddr_in == `REG_CTRL) || (paddr_in == `REG_STATUS) ||
                       (paddr_in == `REG_CORE) || (paddr_in == `REG_CONV);
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `REG_CTRL: rd_mux[`CTRL_RUN] = run_r;
      `REG_STATUS: begin
        rd_mux[13:0]                    = pc_r;
        rd_mux[16:14]                   = stack_index_r;
        rd_mux[`ST_DONE]                = conversion_done_flag_r;
        rd_mux[`ST_OFFM]                = backup_mode_out;
        rd_mux[`ST_ARMED]               = pof_armed_r;
        rd_mux[`ST_WDT]                 = wdt_stop_en_out;
        rd_mux[`ST_OSC_LSB+1:`ST_OSC_LSB] = osc_sel_out;
      end
      `REG_CORE: begin
        rd_mux[3:0]                         = acc_r;
        rd_mux[`CORE_CY]                    = carry_flag_r;
        rd_mux[`CORE_AUX_LSB+2:`CORE_AUX_LSB] = aux_index_reg_r;
        rd_mux[`CORE_DP_LSB+9:`CORE_DP_LSB]   = ram_addr_out;
      end
      `REG_CONV: rd_mux[3:0] = converter_ctrl_one_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out           <= 32'h0000_0000;
      pready_out           <= 1'b0;
      pslverr_out          <= 1'b0;
      run_r                <= `CTRL_RST;
      converter_ctrl_one_r <= `CONV_RST;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup && !mapped;
      if (setup) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
      end
      if (access && pwrite_in) begin
        if (paddr_in == `REG_CTRL) begin
          run_r <= pwdata_in[`CTRL_RUN];
        end
        if (paddr_in == `REG_CONV) begin
          converter_ctrl_one_r <= pwdata_in[3:0];
        end
      end
    end
  end

endmodule // nibble_core

// File: pkg/nibble_core_defines.vh
/*
  constants for the nibble core: instruction encodings, widths, state codes,
  register offsets, reset values and field positions.
  assumes inclusion by bare name from the design files.
*/
`ifndef NIBBLE_CORE_DEFINES_VH
`define NIBBLE_CORE_DEFINES_VH

// widths
`define PC_W          14
`define HALF_W        7
`define DP_W          10
`define IR_W          10
`define STK_DEPTH     8
`define SP_W          3

// exact instruction codes
`define OP_NOP        10'h000
`define OP_POF        10'h002
`define OP_RC         10'h006
`define OP_SC         10'h007
`define OP_AM         10'h00A
`define OP_AND        10'h018
`define OP_SEAM       10'h026
`define OP_TDA        10'h029
`define OP_SZC        10'h02F
`define OP_RT         10'h044
`define OP_RTS        10'h045
`define OP_POWER_OFF_ARM_OP       10'h05B
`define OP_TMA        10'h0AC
`define OP_READ_PORT0_OP       10'h260
`define OP_READ_PORT2_OP       10'h262
`define OP_SEL_CERAMIC_OSC_OP       10'h29A
`define OP_SEL_RC_OSC_OP       10'h29B
`define OP_WATCHDOG_HALT_ARM_OP       10'h29C
`define OP_SEL_CRYSTAL_OSC_OP       10'h29D
`define OP_CONVERTER_START_OP       10'h29F

// instruction groups: prefix value and its width
`define PFX_LA        6'h07
`define PFX_LZ        8'h12
`define PFX_B         3'h3
`define PFX_TABLE_REF_OP      4'h4
`define PFX_LXY       2'h2
`define PFX_BM        4'hC
`define PFX_BL        4'hE
`define PFX_BLA       4'hF

// core states, one-hot
`define ST_IDLE       7'h01
`define ST_FETCH      7'h02
`define ST_EXEC       7'h04
`define ST_WORD2      7'h08
`define ST_TAB        7'h10
`define ST_HOLD       7'h20
`define ST_OFF        7'h40

// oscillator source codes
`define OSC_ONCHIP    2'h0
`define OSC_CERAMIC   2'h1
`define OSC_RC        2'h2
`define OSC_XTAL      2'h3

// register map, byte offsets
`define ADDR_W        8
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_CORE      8'h08
`define REG_CONV      8'h0C

// reset values
`define CTRL_RST      1'b0
`define CONV_RST      4'h0
`define SP_RST        3'h7
`define PC_RST        14'h0000

// field positions
`define CTRL_RUN      0
`define CONV_MODE     3
`define ST_SP_LSB     14
`define ST_DONE       17
`define ST_OFFM       18
`define ST_ARMED      19
`define ST_WDT        20
`define ST_OSC_LSB    21
`define CORE_CY       4
`define CORE_AUX_LSB  5
`define CORE_DP_LSB   8

`endif

// File: testbench/nibble_core_monitor.sv
/* concurrent checks on the nibble core ports, bound to every core instance.
   assumes the defines header is on the include path. */
`timescale 1ns/1ps
`include "nibble_core_defines.vh"
module nibble_core_monitor (
  // clock and reset
  input logic             clk_in,
  input logic             nrst_in,
  // apb
  input logic             psel_in,
  input logic             penable_in,
  input logic             pready_out,
  input logic             pslverr_out,
  // instruction stream
  input logic [`PC_W-1:0] rom_addr_out,
  input logic [`IR_W-1:0] rom_data_in,
  // system control
  input logic             adc_start_out,
  input logic             cmp_start_out,
  input logic             backup_mode_out,
  input logic             wdt_stop_en_out,
  input logic [1:0]       osc_sel_out
);
  logic [`IR_W-1:0] osc_op;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // the on-chip code is only ever reached through reset, so it maps to OP_NOP
  assign osc_op = (osc_sel_out == `OSC_CERAMIC) ? `OP_SEL_CERAMIC_OSC_OP :
                  (osc_sel_out == `OSC_RC) ? `OP_SEL_RC_OSC_OP :
                  (osc_sel_out == `OSC_XTAL) ? `OP_SEL_CRYSTAL_OSC_OP : `OP_NOP;
  chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("ready missing after setup");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  // operand words of far branches and table words are not fetches, so they are left out
  chk_fetch_step: assert property ($changed(rom_addr_out) && rom_data_in == `OP_NOP
    && $past(rom_data_in[9:8]) != 2'b11 && $past(rom_data_in[9:6]) != 4'h4
    |-> ##2 rom_addr_out == $past(rom_addr_out, 2) + 14'h0001)
    else $error("counter did not step by one");
  chk_off_cause: assert property ($rose(backup_mode_out)
    |-> $past(rom_data_in) == `OP_POF && $past(rom_data_in, 3) == `OP_POWER_OFF_ARM_OP)
    else $error("backup entered without armed power-off");
  chk_off_hold: assert property (backup_mode_out |=> backup_mode_out)
    else $error("backup left without reset");
  chk_wdt_cause: assert property ($rose(wdt_stop_en_out)
    |-> $past(rom_data_in) == `OP_WATCHDOG_HALT_ARM_OP)
    else $error("watchdog stop enabled by wrong opcode");
  chk_wdt_hold: assert property (wdt_stop_en_out |=> wdt_stop_en_out)
    else $error("watchdog stop enable dropped");
  chk_osc_cause: assert property ($changed(osc_sel_out)
    |-> $past(rom_data_in) == osc_op)
    else $error("oscillator source changed by wrong opcode");
  chk_start_cause: assert property (adc_start_out || cmp_start_out
    |-> $past(rom_data_in) == `OP_CONVERTER_START_OP && !(adc_start_out && cmp_start_out))
    else $error("converter start without start opcode");
  chk_start_pulse: assert property (adc_start_out || cmp_start_out
    |=> !adc_start_out && !cmp_start_out)
    else $error("converter start longer than one cycle");
  cov_off: cover property ($rose(backup_mode_out));
  cov_adc: cover property (adc_start_out);
  cov_cmp: cover property (cmp_start_out);
  cov_err: cover property (pslverr_out && pready_out);
endmodule // nibble_core_monitor

bind nibble_core nibble_core_monitor u_monitor (.clk_in(clk_in), .nrst_in(nrst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .rom_addr_out(rom_addr_out), .rom_data_in(rom_data_in),
  .adc_start_out(adc_start_out), .cmp_start_out(cmp_start_out),
  .backup_mode_out(backup_mode_out), .wdt_stop_en_out(wdt_stop_en_out),
  .osc_sel_out(osc_sel_out));

// File: testbench/nibble_cpu_instruction_exec_tb_top.sv
/* self-checking bench: short fixed programs with random operands run from the memory model.
   assumes the core, its defines header, monitor and memory model are compiled first. */
`timescale 1ns/1ps
`include "nibble_core_defines.vh"
module nibble_cpu_instruction_exec_tb_top;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic        conv_done_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [3:0]  port0_in = 4'h0;
  logic [2:0]  port2_in = 3'h0;
  logic [31:0] prdata_out, rd, rnd;
  logic [13:0] rom_addr_out;
  logic [9:0]  rom_data_in, ram_addr_out;
  logic [3:0]  ram_rdata_in, ram_wdata_out, n, m, a_am, md;
  logic [5:0]  p;
  logic [3:0]  p0v;
  logic [2:0]  p2v;
  logic [6:0]  a;
  logic [1:0]  osc_sel_out;
  logic        pready_out, pslverr_out, ram_we_out, adc_start_out, cmp_start_out;
  logic        backup_mode_out, wdt_stop_en_out, err;
  logic [9:0]  prog [0:15];
  int          n_fail = 0, total_checks = 0, cycles = 0, n_adc = 0, n_cmp = 0;
  int          seed = 32'h6c0b;

  nibble_core u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .rom_addr_out(rom_addr_out), .rom_data_in(rom_data_in),
    .ram_addr_out(ram_addr_out), .ram_rdata_in(ram_rdata_in), .ram_wdata_out(ram_wdata_out),
    .ram_we_out(ram_we_out), .port0_in(port0_in), .port2_in(port2_in),
    .conv_done_in(conv_done_in), .adc_start_out(adc_start_out), .cmp_start_out(cmp_start_out),
    .backup_mode_out(backup_mode_out), .wdt_stop_en_out(wdt_stop_en_out),
    .osc_sel_out(osc_sel_out));
  nibble_mem_model u_mem (.clk_in(clk_in), .rom_addr_in(rom_addr_out),
    .rom_data_out(rom_data_in), .ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out),
    .ram_we_in(ram_we_out), .ram_rdata_out(ram_rdata_in));

  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    n_adc += (adc_start_out === 1'b1);
    n_cmp += (cmp_start_out === 1'b1);
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= ad;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    rd = prdata_out;
    err = pslverr_out;
    if (i == 16) check("pready", 32'h0000_0001, 32'h0000_0000);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic load(input int k, input logic arm);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    n_adc = 0;
    n_cmp = 0;
    for (int i = 0; i < 16384; i++) u_mem.rom[i] = `OP_NOP;
    for (int i = 0; i < k; i++) u_mem.rom[i] = prog[i];
    if (!arm) u_mem.rom[14] = `OP_NOP;
    u_mem.rom[k] = {3'h3, k[6:0]};
    u_mem.ram[0] = m;
  endtask
  // the done flag is set first so that the start opcode has something to clear
  task automatic start(input logic [13:0] stop, input logic [7:0] ra);
    int i;
    @(posedge clk_in);
    conv_done_in <= 1'b1;
    @(posedge clk_in);
    conv_done_in <= 1'b0;
    apb(1'b1, `REG_CONV, {28'h0, md});
    apb(1'b1, `REG_CTRL, 32'h0000_0001);
    for (i = 0; i < 400 && rom_addr_out !== stop; i++) @(posedge clk_in);
    check("fetch address", {18'h0, stop}, {18'h0, rom_addr_out});
    apb(1'b0, ra, 32'h0000_0000);
  endtask
  task automatic step(input int k, input logic arm);
    load(k, arm);
    start((k > 15) ? 14'h000F : k[13:0], `REG_CORE);
  endtask

  initial begin
    load(0, 1'b1);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    check("status at reset", 32'h0001_C000, rd);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    check("unmapped error", 32'h0000_0001, {31'h0, err});
    for (int r = 0; r < 3; r++) begin
      rnd = $random(seed);
      {a, p, p2v, p0v, md, m, n} = rnd;
      port2_in <= p2v;
      port0_in <= p0v;
      p[5] = 1'b1;
      md[3] = r[0];
      a_am = (n & m) + m;
      prog = '{`OP_SC, {6'h07, n}, `OP_AND, `OP_AM, `OP_RC, `OP_SZC, {6'h07, ~a_am}, `OP_READ_PORT2_OP,
               `OP_READ_PORT0_OP, `OP_SEL_CERAMIC_OSC_OP, `OP_WATCHDOG_HALT_ARM_OP, `OP_CONVERTER_START_OP, `OP_SEL_RC_OSC_OP, `OP_SEL_CRYSTAL_OSC_OP, `OP_POWER_OFF_ARM_OP, `OP_POF};
      step(3, 1'b1);
      check("and result", {27'h0, 1'b1, n & m}, rd);
      step(4, 1'b1);
      check("add result", {27'h0, 1'b1, a_am}, rd);
      step(7, 1'b1);
      check("skipped load", {27'h0, 1'b0, a_am}, rd);
      step(8, 1'b1);
      check("port two", {27'h0, 1'b0, a_am[3], port2_in}, rd);
      step(9, 1'b1);
      check("port zero", {27'h0, 1'b0, port0_in}, rd);
      step(12, 1'b1);
      check("starts", md[3] ? 32'h0000_0100 : 32'h0000_0001, n_cmp * 256 + n_adc);
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      check("status flags", 32'h0031_C000, rd & 32'hFFFF_C000);
      step(13, 1'b1);
      check("rc source", 32'h0000_0002, {30'h0, osc_sel_out});
      step(14, 1'b1);
      check("crystal source", 32'h0000_0003, {30'h0, osc_sel_out});
      step(16, 1'b1);
      check("kept core", {27'h0, 1'b0, port0_in}, rd);
      check("backup", 32'h0000_0001, {31'h0, backup_mode_out});
      step(16, 1'b0);
      check("unarmed off", 32'h0000_0000, {31'h0, backup_mode_out});
    end
    load(0, 1'b1);
    u_mem.rom[0] = {4'hE, p};
    u_mem.rom[1] = {3'h0, a};
    u_mem.rom[{1'b0, p, a}] = {3'h3, ~a};
    u_mem.rom[{1'b0, p, ~a}] = {3'h3, ~a};
    start({1'b0, p, ~a}, `REG_STATUS);
    load(0, 1'b1);
    u_mem.rom[0] = {6'h07, n};
    u_mem.rom[1] = {4'hF, p};
    u_mem.rom[{1'b0, p, 3'h0, n}] = {3'h3, 3'h0, n};
    start({1'b0, p, 3'h0, n}, `REG_STATUS);
    load(0, 1'b1);
    u_mem.rom[0] = {4'hC, p};
    u_mem.rom[1] = {3'h0, a};
    u_mem.rom[{1'b0, p, a}] = `OP_RT;
    u_mem.rom[2] = {3'h3, 7'h02};
    start(14'h0002, `REG_STATUS);
    check("stack after return", 32'h0001_C000, rd & 32'h0001_C000);
    prog[0] = {6'h07, ~m};
    prog[1] = `OP_TMA;
    prog[2] = `OP_RC;
    prog[3] = `OP_SZC;
    prog[4] = `OP_RT;
    step(5, 1'b1);
    check("skipped return", {27'h0, 1'b0, ~m}, rd & 32'h0000_001F);
    check("ram write", {28'h0, ~m}, {28'h0, u_mem.ram[0]});
    end_of_test();
  end
endmodule // nibble_cpu_instruction_exec_tb_top

// File: testbench/nibble_mem_model.sv
/* program rom and data ram beside the core, both read asynchronously.
   assumes the bench loads contents by hierarchical writes while the core is idle. */
`timescale 1ns/1ps
module nibble_mem_model (
  // clock
  input  logic        clk_in,
  // program side
  input  logic [13:0] rom_addr_in,
  output logic [9:0]  rom_data_out,
  // data side
  input  logic [9:0]  ram_addr_in,
  input  logic [3:0]  ram_wdata_in,
  input  logic        ram_we_in,
  output logic [3:0]  ram_rdata_out
);
  logic [9:0] rom [0:16383];
  logic [3:0] ram [0:1023];
  assign rom_data_out = rom[rom_addr_in];
  // cells never written read unknown, as a cold part would
  assign ram_rdata_out = ram[ram_addr_in];
  always @(posedge clk_in) begin
    if (ram_we_in === 1'b1) ram[ram_addr_in] <= ram_wdata_in;
  end
endmodule // nibble_mem_model
